//--- pkg/fps_pkg.sv
// package: register map, fields, timing constants and carriers of the flash sequencer
package fps_pkg;
   // register byte offsets
   localparam logic [11:0] FPS_CTRL_OFS = 12'h000;
   localparam logic [11:0] FPS_STAT_OFS = 12'h004;
   localparam logic [11:0] FPS_PARAM_OFS = 12'h008;
   localparam logic [11:0] FPS_ADDR_OFS = 12'h00c;
   localparam logic [11:0] FPS_PROT_OFS = 12'h010;
   localparam logic [11:0] FPS_DATA_OFS = 12'h014;
   localparam logic [11:0] FPS_INDEX_OFS = 12'h018;
   // control fields
   localparam int FPS_CTRL_ERASE_BIT = 0;
   localparam int FPS_CTRL_PROG_BIT = 1;
   localparam int FPS_CTRL_WDDIS_BIT = 2;
   // status fields
   localparam int FPS_STAT_BUSY_BIT = 0;
   localparam int FPS_STAT_REFUSED_BIT = 1;
   localparam int FPS_STAT_IMASK_BIT = 2;
   localparam int FPS_STAT_MASS_BIT = 3;
   // reset values and mass-erase address
   localparam logic [15:0] FPS_PROT_RST = 16'hffff;
   localparam logic [15:0] FPS_BPR_ADDR = 16'hff7e;
   localparam logic [7:0] FPS_SPEED_RST = 8'h20;
   // geometry
   localparam int FPS_ROW_BYTES = 32;
   localparam int FPS_PAGE_BYTES = 64;
   // timing in bus cycles of the flash clock, _US values in microseconds (speed_param = 4 x MHz)
   localparam int FPS_PROG_LOW_CYC = 57;
   localparam int FPS_PROG_MUL = 8;
   localparam int FPS_PROG_ADD = 8;
   localparam int FPS_WD_FIRST_CYC = 61;
   localparam int FPS_HV_MAX_US = 125;
   localparam int FPS_HV_ROW_MAX_US = 4000;
   localparam int FPS_ERASE_MIN_US = 4000;
   localparam int FPS_ERASE_MAX_US = 5500;
   // erase length in speed units: 4.5 ms x MHz x 4 / 4 = 4500 cycles per MHz
   localparam int FPS_ERASE_US = 4500;
   localparam int FPS_SETUP_CYC = 4;
   // pclk 50 MHz, flash bus at speed/4 MHz: one flash cycle = 200/speed pclk
   localparam int FPS_PCLK_MHZ = 50;
   localparam int FPS_PCLK_X4 = FPS_PCLK_MHZ * 4;

   typedef enum logic [2:0] {
      FPS_IDLE = 3'b000,
      FPS_SETUP = 3'b001,
      FPS_PULSE = 3'b010,
      FPS_NEXT = 3'b011,
      FPS_ERASE = 3'b100,
      FPS_DONE = 3'b101
   } fps_state_t;

   typedef struct packed {
      logic hv;
      logic erase;
      logic mass;
      logic row;
      logic [15:0] addr;
      logic [4:0] len;
   } fps_flash_t;
endpackage

//--- src/fps_tick.sv
// divider: one tick per flash bus cycle from pclk
`timescale 1ns/1ps
module fps_tick
   import fps_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // control
   input wire logic run,
   input wire logic [7:0] speed,
   output logic tick
);
   typedef struct packed {
      logic [15:0] acc;
      logic tick;
   } fps_tick_st_t;
   fps_tick_st_t s_q, s_d;
   logic [16:0] sum;

   // fractional accumulator: adds speed, wraps at 4 x pclk MHz
   always_comb begin
      s_d = s_q;
      sum = {1'b0, s_q.acc} + {9'h000, speed};
      s_d.tick = 1'b0;
      if (!run) begin
         s_d.acc = 16'h0000;
      end else if (sum >= 17'(FPS_PCLK_X4)) begin
         s_d.acc = 16'(sum - 17'(FPS_PCLK_X4));
         s_d.tick = 1'b1;
      end else begin
         s_d.acc = sum[15:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign tick = s_q.tick;
endmodule // fps_tick

//--- src/fps_seq.sv
// flash erase and program sequencer with apb register access
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module fps_seq
   import fps_pkg::*;
#(
   parameter int DATA_DEPTH = 256,
   parameter int ERASE_US = FPS_ERASE_US
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // system
   input wire logic test_high_voltage,
   input wire logic irq_mask_in,
   output logic irq_mask,
   output logic watchdog_kick,
   // flash array
   output fps_flash_t flash,
   output logic [7:0] flash_wdata,
   output logic [4:0] flash_col
);
   initial begin
      if (DATA_DEPTH < 1 || DATA_DEPTH > 256) begin
         $error("fps_seq: DATA_DEPTH must be 1 to 256");
      end
      // erase count must fit 16 bits at the top speed of 32
      if (ERASE_US < 1 || ERASE_US * 8 > 32'h0000ffff) begin
         $error("fps_seq: ERASE_US must be 1 to 8191");
      end
   end

   typedef struct packed {
      fps_state_t st;
      logic [7:0] speed;
      logic [7:0] count;
      logic [15:0] addr;
      logic [15:0] prot;
      logic wd_dis;
      logic refused;
      logic imask_save;
      logic imask;
      logic mass;
      logic [7:0] done_n;
      logic [7:0] chunk;
      logic [15:0] cyc;
      logic [15:0] wd_cyc;
      logic wd_first;
      logic kick;
      logic [7:0] dptr;
      logic [7:0] ld_n;
      logic [7:0] wdata;
      logic [4:0] col;
      logic [15:0] hv_pclk;
      fps_flash_t fl;
      logic [31:0] rdata;
   } fps_st_t;
   fps_st_t s_q, s_d;

   logic [7:0] data_mem [DATA_DEPTH];
   logic tick;
   logic wr_en, rd_en;
   logic [15:0] pulse_cyc;
   logic [15:0] erase_cyc;
   logic [15:0] last_addr;
   logic [15:0] last_row;
   logic [15:0] cur_addr;
   logic row_ok;

   fps_tick fps_tick_i (
      .pclk(pclk),
      .presetn(presetn),
      .run(s_q.st != FPS_IDLE),
      .speed(s_q.speed),
      .tick(tick)
   );

   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && !penable && !pwrite;
   assign pready = 1'b1;
   assign pslverr = 1'b0;

   // pulse length in flash cycles from speed
   always_comb begin
      if (s_q.speed <= 8'd7) begin
         pulse_cyc = 16'(FPS_PROG_LOW_CYC);
      end else begin
         pulse_cyc = 16'(FPS_PROG_MUL) * {8'h00, s_q.speed} + 16'(FPS_PROG_ADD);
      end
   end
   // erase: ERASE_US x (speed/4) flash cycles
   assign erase_cyc = 16'((32'(ERASE_US) * 32'(s_q.speed)) >> 2);

   assign cur_addr = s_q.addr + {8'h00, s_q.done_n};
   assign last_addr = s_q.addr + {8'h00, s_q.count} - 16'h0001;
   assign last_row = last_addr & ~16'(FPS_ROW_BYTES - 1);
   // row method only with watchdog off and remaining bytes in last row
   assign row_ok = s_q.wd_dis && (cur_addr >= last_row || cur_addr[15:5] == last_row[15:5]);

   always_comb begin
      s_d = s_q;
      s_d.kick = 1'b0;
      if (rd_en) begin
         if (paddr == FPS_CTRL_OFS) begin
            s_d.rdata = {29'h0, s_q.wd_dis, 2'b00};
         end else if (paddr == FPS_STAT_OFS) begin
            s_d.rdata = {28'h0, s_q.mass, s_q.imask, s_q.refused, s_q.st != FPS_IDLE};
         end else if (paddr == FPS_PARAM_OFS) begin
            s_d.rdata = {16'h0, s_q.count, s_q.speed};
         end else if (paddr == FPS_ADDR_OFS || paddr == FPS_INDEX_OFS) begin
            s_d.rdata = {16'h0, s_q.addr};
         end else if (paddr == FPS_PROT_OFS) begin
            s_d.rdata = {16'h0, s_q.prot};
         end else begin
            s_d.rdata = 32'h0;
         end
      end
      if (s_q.st == FPS_IDLE && wr_en) begin
         if (paddr == FPS_CTRL_OFS) begin
            s_d.wd_dis = pwdata[FPS_CTRL_WDDIS_BIT];
            s_d.dptr = 8'h00;
            if (pwdata[FPS_CTRL_ERASE_BIT]) begin
               s_d.mass = (s_q.addr == FPS_BPR_ADDR);
               s_d.refused = 1'b0;
               s_d.imask_save = irq_mask_in;
               s_d.imask = 1'b1;
               s_d.st = FPS_ERASE;
               // fresh watchdog schedule for every operation
               s_d.wd_cyc = 16'h0;
               s_d.wd_first = 1'b1;
               s_d.cyc = 16'h0;
               if (s_q.addr == FPS_BPR_ADDR && !test_high_voltage) begin
                  s_d.refused = 1'b1;
                  s_d.st = FPS_DONE;
               end else if (s_q.addr != FPS_BPR_ADDR && s_q.addr >= s_q.prot
                            && !test_high_voltage) begin
                  s_d.refused = 1'b1;
                  s_d.st = FPS_DONE;
               end
            end else if (pwdata[FPS_CTRL_PROG_BIT]) begin
               s_d.refused = 1'b0;
               s_d.mass = 1'b0;
               s_d.done_n = 8'h00;
               s_d.ld_n = 8'h00;
               s_d.imask_save = irq_mask_in;
               s_d.imask = 1'b1;
               s_d.wd_cyc = 16'h0;
               s_d.wd_first = 1'b1;
               s_d.st = (s_q.count == 8'h00) ? FPS_DONE : FPS_SETUP;
               s_d.cyc = 16'h0;
            end
         end else if (paddr == FPS_PARAM_OFS) begin
            s_d.speed = pwdata[7:0];
            s_d.count = pwdata[15:8];
         end else if (paddr == FPS_ADDR_OFS) begin
            s_d.addr = pwdata[15:0];
         end else if (paddr == FPS_PROT_OFS) begin
            s_d.prot = pwdata[15:0];
         end else if (paddr == FPS_DATA_OFS) begin
            s_d.dptr = s_q.dptr + 8'h01;
         end
      end
      // watchdog service while running, watchdog enabled
      if (s_q.st != FPS_IDLE && !s_q.wd_dis && tick) begin
         s_d.wd_cyc = s_q.wd_cyc + 16'h0001;
         if (s_q.wd_cyc == 16'(FPS_WD_FIRST_CYC - 1) && s_q.wd_first) begin
            s_d.kick = 1'b1;
            s_d.wd_first = 1'b0;
            s_d.wd_cyc = 16'h0;
         end else if (!s_q.wd_first && s_q.wd_cyc == pulse_cyc) begin
            s_d.kick = 1'b1;
            s_d.wd_cyc = 16'h0;
         end
      end
      case (s_q.st)
         FPS_SETUP: begin
            if (row_ok) begin
               s_d.chunk = s_q.count - s_q.done_n;
            end else begin
               s_d.chunk = 8'h01;
            end
            s_d.fl.erase = 1'b0;
            s_d.fl.mass = 1'b0;
            s_d.fl.row = row_ok;
            s_d.fl.addr = cur_addr;
            s_d.fl.len = row_ok ? 5'(s_q.count - s_q.done_n - 8'h01) : 5'h00;
            s_d.cyc = 16'h0;
            s_d.hv_pclk = 16'h0;
            // one byte per cycle into the row latch; row method loops first
            s_d.wdata = data_mem[8'(s_q.done_n + s_q.ld_n)];
            s_d.col = cur_addr[4:0] + s_q.ld_n[4:0];
            s_d.ld_n = s_q.ld_n + 8'h01;
            if (!row_ok || s_q.ld_n == s_q.count - s_q.done_n - 8'h01) begin
               s_d.ld_n = 8'h00;
               s_d.st = FPS_PULSE;
            end
         end
         FPS_PULSE: begin
            s_d.fl.hv = 1'b1;
            s_d.hv_pclk = s_q.hv_pclk + 16'h0001;
            if (tick) begin
               s_d.cyc = s_q.cyc + 16'h0001;
               if (s_q.cyc == pulse_cyc - 16'h0001) begin
                  s_d.fl.hv = 1'b0;
                  s_d.st = FPS_NEXT;
               end
            end
            // hard cap on high voltage when speed is set far too low
            if (s_q.hv_pclk == 16'(FPS_HV_MAX_US * FPS_PCLK_MHZ - 1)) begin
               s_d.fl.hv = 1'b0;
               s_d.st = FPS_NEXT;
            end
         end
         FPS_NEXT: begin
            s_d.done_n = s_q.done_n + s_q.chunk;
            s_d.st = (s_q.done_n + s_q.chunk >= s_q.count) ? FPS_DONE : FPS_SETUP;
         end
         FPS_ERASE: begin
            s_d.fl.erase = 1'b1;
            s_d.fl.mass = s_q.mass;
            s_d.fl.row = 1'b0;
            s_d.fl.addr = s_q.addr & ~16'(FPS_PAGE_BYTES - 1);
            s_d.fl.hv = 1'b1;
            if (tick) begin
               s_d.cyc = s_q.cyc + 16'h0001;
               if (s_q.cyc == erase_cyc - 16'h0001) begin
                  s_d.fl.hv = 1'b0;
                  s_d.st = FPS_DONE;
               end
            end
         end
         FPS_DONE: begin
            s_d.fl.hv = 1'b0;
            s_d.fl.erase = 1'b0;
            s_d.imask = s_q.imask_save;
            if (!s_q.fl.erase && !s_q.refused && !s_q.mass) begin
               s_d.addr = s_q.addr + {8'h00, s_q.done_n};
            end
            s_d.st = FPS_IDLE;
         end
         default: begin
         end
      endcase
   end

   // data array written through the data window, auto-increment
   always_ff @(posedge pclk) begin
      if (s_q.st == FPS_IDLE && wr_en && paddr == FPS_DATA_OFS) begin
         data_mem[s_q.dptr] <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
         s_q.prot <= FPS_PROT_RST;
         s_q.speed <= FPS_SPEED_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata = s_q.rdata;
   assign irq_mask = s_q.imask;
   assign watchdog_kick = s_q.kick;
   assign flash = s_q.fl;
   assign flash_wdata = s_q.wdata;
   assign flash_col = s_q.col;
endmodule // fps_seq

//--- test/fps_seq_asserts.sv
// checker: pulse timing and interlocks of the flash sequencer
`timescale 1ns/1ps
module fps_seq_asserts
   import fps_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // observed
   input wire logic test_high_voltage,
   input wire logic irq_mask,
   input wire logic watchdog_kick,
   input wire fps_flash_t flash
);
   int unsigned hv_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) hv_q <= 0;
      else hv_q <= flash.hv ? hv_q + 1 : 0;
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // end of a program pulse, length held in hv_q
   sequence prog_end;
      $fell(flash.hv) && !$past(flash.erase);
   endsequence
   pulse_min_a: assert property (prog_end |-> hv_q >= 1500) else $error("short pulse");
   pulse_max_a: assert property (prog_end |-> hv_q <= 2000) else $error("long pulse");
   hv_cap_a: assert property (flash.hv && !flash.erase |-> hv_q < 6250) else $error("hv");
   hv_masked_a: assert property (flash.hv |-> irq_mask) else $error("unmasked");
   mask_first_a: assert property ($rose(flash.hv) |-> $past(irq_mask)) else $error("late");
   kick_pulse_a: assert property (watchdog_kick |=> !watchdog_kick) else $error("kick");
   mass_tst_a: assert property (flash.hv && flash.mass |-> test_high_voltage) else $error("m");
   mass_erase_a: assert property (flash.hv && flash.mass |-> flash.erase) else $error("e");
endmodule // fps_seq_asserts
bind fps_seq fps_seq_asserts fps_seq_asserts_i (.pclk(pclk), .presetn(presetn),
   .test_high_voltage(test_high_voltage), .irq_mask(irq_mask),
   .watchdog_kick(watchdog_kick), .flash(flash));

//--- test/fps_flash_model.sv
// flash array stand-in: tallies pulses and kicks at the array side
`timescale 1ns/1ps
module fps_flash_model
   import fps_pkg::*;
(
   // clock and tally clear
   input wire logic pclk,
   input wire logic clr,
   // array side
   input wire fps_flash_t flash,
   input wire logic watchdog_kick,
   input wire logic [7:0] flash_wdata,
   input wire logic [4:0] flash_col,
   // tallies
   output int n_prog,
   output int n_row,
   output int n_kick,
   output int n_erase,
   output int n_mass,
   output int last_len,
   output logic [15:0] er_addr,
   output logic [31:0][7:0] pbuf
);
   int len;
   bit hv_d;
   always @(posedge pclk) begin
      hv_d <= flash.hv;
      len <= flash.hv ? len + 1 : 0;
      if (flash.hv && !hv_d) begin
         if (flash.erase) n_erase <= n_erase + 1;
         else n_prog <= n_prog + 1;
         if (flash.row) n_row <= n_row + 1;
         if (flash.mass) n_mass <= n_mass + 1;
         er_addr <= flash.addr;
      end
      if (!flash.hv && hv_d) last_len <= len;
      if (watchdog_kick) n_kick <= n_kick + 1;
      // row bytes latch while hv is low, a single byte during its pulse
      if (!flash.erase && (flash.row != flash.hv)) pbuf[flash_col] <= flash_wdata;
      // clear wins over any counter update; last_len, er_addr and pbuf keep their values
      if (clr) begin
         n_prog <= 0;
         n_row <= 0;
         n_kick <= 0;
         n_erase <= 0;
         n_mass <= 0;
      end
   end
endmodule // fps_flash_model

//--- test/fps_seq_tb.sv
// self-checking bench: apb-driven erase and program runs
`timescale 1ns/1ps
module fps_seq_tb;
   import fps_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, tst, imask_in, clr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, irq_mask, kick;
   logic [15:0] er_addr;
   logic [7:0] wdat;
   logic [4:0] col;
   logic [31:0][7:0] pbuf;
   fps_flash_t flash;
   int n_fail, samples_checked, n_prog, n_row, n_kick, n_erase, n_mass, last_len;
   fps_seq #(.ERASE_US(10)) fps_seq_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .test_high_voltage(tst), .irq_mask_in(imask_in),
      .irq_mask(irq_mask), .watchdog_kick(kick), .flash(flash), .flash_wdata(wdat),
      .flash_col(col));
   fps_flash_model fps_flash_model_i (.pclk(pclk), .clr(clr), .flash(flash),
      .watchdog_kick(kick), .flash_wdata(wdat), .flash_col(col), .n_prog(n_prog),
      .n_row(n_row), .n_kick(n_kick), .n_erase(n_erase), .n_mass(n_mass),
      .last_len(last_len), .er_addr(er_addr), .pbuf(pbuf));
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1) @(posedge pclk);
      rd = prdata;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         n_fail++;
      end
   endtask
   // load the parameter block, start, poll until idle
   task automatic run(input logic [7:0] spd, input logic [7:0] cnt, input logic [15:0] adr,
      input logic [2:0] ctl);
      clr <= 1'h1;
      apb(1'h1, FPS_PARAM_OFS, {16'h0, cnt, spd});
      clr <= 1'h0;
      apb(1'h1, FPS_ADDR_OFS, {16'h0, adr});
      for (int i = 0; i < cnt; i++) apb(1'h1, FPS_DATA_OFS, {24'h0, 8'(i) ^ 8'h55});
      apb(1'h1, FPS_CTRL_OFS, {29'h0, ctl});
      rd = 32'h1;
      for (int i = 0; i < 3000 && rd[0]; i++) apb(1'h0, FPS_STAT_OFS, 32'h0);
      chk(rd[0], 1'h0);
   endtask
   task automatic index(input logic [31:0] exp);
      apb(1'h0, FPS_INDEX_OFS, 32'h0);
      chk(rd, exp);
   endtask
   task automatic final_report();
      $display("checks=%0d errors=%0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      pclk = 1'h0;
      forever #10 pclk = ~pclk;
   end
   initial begin
      repeat (50000) @(posedge pclk);
      n_fail++;
      final_report();
   end
   initial begin
      presetn = 1'h0;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      tst = 1'h0;
      imask_in = 1'h1;
      clr = 1'h0;
      repeat (4) @(posedge pclk);
      presetn <= 1'h1;
      run(8'h20, 8'h2, 16'hc0f0, 3'h2);
      chk(n_prog, 2);
      chk(n_row, 0);
      chk(n_kick > 0, 1);
      chk(last_len >= 1500 && last_len <= 2000, 1);
      chk(irq_mask, imask_in);
      chk(pbuf[16], 8'h55);
      chk(pbuf[17], 8'h54);
      index(32'hc0f2);
      imask_in <= 1'h0;
      run(8'h6, 8'h20, 16'hc000, 3'h6);
      chk(n_prog, 1);
      chk(n_row, 1);
      chk(last_len >= 1500 && last_len <= 2000, 1);
      chk(irq_mask, imask_in);
      for (int i = 0; i < 32; i++) chk(pbuf[i], 8'(i) ^ 8'h55);
      index(32'hc020);
      run(8'h20, 8'h4, 16'h001e, 3'h6);
      chk(n_prog, 3);
      chk(n_row, 1);
      chk(er_addr, 16'h0020);
      chk(pbuf[30], 8'h55);
      chk(pbuf[0], 8'h57);
      chk(pbuf[1], 8'h56);
      index(32'h0022);
      run(8'h20, 8'h0, 16'h1234, 3'h2);
      chk(n_prog, 0);
      index(32'h1234);
      apb(1'h1, FPS_PROT_OFS, 32'h0);
      run(8'h20, 8'h0, 16'he121, 3'h1);
      chk(rd[1], 1'h1);
      chk(n_erase, 0);
      tst <= 1'h1;
      run(8'h20, 8'h0, 16'he121, 3'h1);
      chk(n_erase, 1);
      chk(er_addr[15:6], 10'h384);
      tst <= 1'h0;
      run(8'h20, 8'h0, FPS_BPR_ADDR, 3'h1);
      chk(rd[1], 1'h1);
      chk(n_mass, 0);
      tst <= 1'h1;
      run(8'h20, 8'h0, FPS_BPR_ADDR, 3'h1);
      chk(n_mass, 1);
      final_report();
   end
endmodule // fps_seq_tb
